// ==== design/evim_top.sv ====
// evim_top: exception classifier and interrupt source map.
// assumes events are one-cycle pulses synchronous to clk_i.
// Functional notes
// - coprocessor unusable: general vector, cu, exception_level, code 0x0B
// - reserved opcode: general vector, exception_level, code 0x0A
// - signed overflow: general vector, exception_level, code 0x0C
// - true trap condition: general vector, code 0x0D; false raises nothing
// - misaligned store: general vector, exception_level, code 0x05
// - load/store bus error: general vector, exception_level, code 0x07
// - load data break: probe-dependent debug vector, load-break flag
// - store data break: same debug vectors, store-break flag
// - interrupt handler address is base plus vector times programmable spacing
// - flag/enable at bit n mod 32; priority fields at 8k offsets
// - unmasked interrupt taken with code 0x00 and updates level
// - seven usable priority levels, four subpriority levels
`timescale 1ns/10ps
module evim_top
  import evim_pkg::*;
#(
  parameter int NUM_VEC = evim_pkg::EVIM_NUM_VEC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [evim_pkg::EVIM_AW-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // core exception events
  input wire logic cop_unusable_i,
  input wire logic [3:0] cop_num_i,
  input wire logic reserved_opcode_fault_i,
  input wire logic signed_arith_excess_i,
  input wire logic trap_exec_i,
  input wire logic trap_cond_i,
  input wire logic data_break_load_i,
  input wire logic data_break_store_i,
  input wire logic store_misalign_i,
  input wire logic load_store_bus_fault_i,
  input wire logic complex_breakpoint_i,
  input wire logic [2:0] complex_break_kind_i,
  input wire logic probe_attached_i,
  input wire logic exc_ack_i,
  // interrupt sources
  input wire logic core_timer_i,
  input wire logic [1:0] core_soft_i,
  input wire logic [4:0] ext_irq_i,
  input wire logic [3:0] change_notice_i,
  input wire logic [2:0] timer_irq_i,
  input wire logic [2:0] comparator_irq_i,
  // core side
  output logic exc_req_o,
  output logic [31:0] exc_target_o,
  output logic [4:0] cause_code_o,
  output logic exception_level_o,
  output logic [3:0] coprocessor_unusable_field_o,
  output logic debug_mode_o,
  output logic [4:0] debug_flags_o,
  output logic [2:0] current_priority_level_o,
  output logic irq_o
);
  import evim_pkg::*;

  localparam int PAW = 3;
  localparam logic [7:0] PRIO_END = 8'(EVIM_OFS_PRIO0 + 4 * EVIM_PRIO_WORDS);
  evim_state_type state_q;
  logic [NUM_VEC-1:0] flag_q, enable_q, src_vec;
  logic [EVIM_NUM_EXC-1:0] exc_stat_q, exc_mask_q, exc_evt;
  logic [31:0] vbase_q, spacing_q;
  logic [4:0] cause_q;
  logic [31:0] target_q;
  logic exl_q, dbg_q, irq_q;
  logic [3:0] cu_q;
  logic [4:0] dflags_q;
  logic [2:0] ipl_q;
  logic [31:0] rdata_q;
  logic rd_prio_q;
  logic [31:0] prio_rdata;
  logic [EVIM_PRIO_WORDS*32-1:0] prio_all;
  logic prio_we;

  function automatic logic [4:0] vec_prio(
    input logic [EVIM_PRIO_WORDS*32-1:0] p,
    input int n);
    vec_prio = p[(n/4)*32 + (n%4)*8 +: 5];
  endfunction

  always_comb
  begin
    src_vec = '0;
    src_vec[0] = core_timer_i;
    src_vec[2:1] = core_soft_i;
    src_vec[7:3] = ext_irq_i;
    src_vec[11:8] = change_notice_i;
    src_vec[19:17] = timer_irq_i;
    src_vec[25:23] = comparator_irq_i;
  end

  always_comb
  begin
    exc_evt = '0;
    exc_evt[EVIM_X_CPU] = cop_unusable_i;
    exc_evt[EVIM_X_RSV] = reserved_opcode_fault_i;
    exc_evt[EVIM_X_OVF] = signed_arith_excess_i;
    exc_evt[EVIM_X_TRAP] = trap_exec_i & trap_cond_i;
    exc_evt[EVIM_X_DBL] = data_break_load_i;
    exc_evt[EVIM_X_DBS] = data_break_store_i;
    exc_evt[EVIM_X_STMIS] = store_misalign_i;
    exc_evt[EVIM_X_BUS] = load_store_bus_fault_i;
    exc_evt[EVIM_X_COMPLEX_BREAKPOINT] = complex_breakpoint_i;
  end

  // best pending interrupt: highest priority, then subpriority, then low n
  logic best_v;
  logic [4:0] best_p;
  logic [4:0] best_n;
  always_comb
  begin
    best_v = 1'b0;
    best_p = 5'h00;
    best_n = 5'h00;
    for (int n = 0; n < NUM_VEC; n++)
    begin
      if (flag_q[n] && enable_q[n] && (vec_prio(prio_all, n) >> 2) != 5'h00
          && (!best_v || vec_prio(prio_all, n) > best_p))
      begin
        best_v = 1'b1;
        best_p = vec_prio(prio_all, n);
        best_n = 5'(n);
      end
    end
  end

  // only priority above the current level interrupts
  logic int_take;
  assign int_take = best_v && (best_p[4:2] > ipl_q) && !exl_q && !dbg_q;

  // first set bit in priority order
  logic exc_any;
  logic [3:0] exc_idx;
  always_comb
  begin
    exc_any = 1'b0;
    exc_idx = 4'h0;
    for (int i = EVIM_NUM_EXC - 1; i >= 0; i--)
    begin
      if (exc_evt[i])
      begin
        exc_any = 1'b1;
        exc_idx = 4'(i);
      end
    end
  end

  // take state
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_q <= EVIM_IDLE;
    else
    begin
      case (state_q)
        EVIM_IDLE: if (exc_any || int_take) state_q <= EVIM_HOLD;
        EVIM_HOLD: if (exc_ack_i) state_q <= EVIM_IDLE;
        default: state_q <= EVIM_IDLE;
      endcase
    end
  end

  logic taking;
  assign taking = (state_q == EVIM_IDLE) && (exc_any || int_take);

  // vector target and cause
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      target_q <= 32'h0000_0000;
      cause_q <= EVIM_CC_INT;
      exl_q <= 1'b0;
      dbg_q <= 1'b0;
      cu_q <= 4'h0;
      dflags_q <= 5'h00;
      ipl_q <= 3'h0;
    end
    else if (taking && exc_any)
    begin
      case (int'(exc_idx))
        EVIM_X_CPU:
        begin
          target_q <= vbase_q + EVIM_GEN_OFS;
          cause_q <= EVIM_CC_CPU;
          exl_q <= 1'b1;
          cu_q <= cop_num_i;
        end
        EVIM_X_RSV:
        begin
          target_q <= vbase_q + EVIM_GEN_OFS;
          cause_q <= EVIM_CC_RSV;
          exl_q <= 1'b1;
        end
        EVIM_X_OVF:
        begin
          target_q <= vbase_q + EVIM_GEN_OFS;
          cause_q <= EVIM_CC_OVF;
          exl_q <= 1'b1;
        end
        EVIM_X_TRAP:
        begin
          target_q <= vbase_q + EVIM_GEN_OFS;
          cause_q <= EVIM_CC_TRAP;
          exl_q <= 1'b1;
        end
        EVIM_X_DBL:
        begin
          target_q <= probe_attached_i ? EVIM_DBG_PROBE : EVIM_DBG_NOPROBE;
          dbg_q <= 1'b1;
          dflags_q <= 5'b00001;
        end
        EVIM_X_DBS:
        begin
          target_q <= probe_attached_i ? EVIM_DBG_PROBE : EVIM_DBG_NOPROBE;
          dbg_q <= 1'b1;
          dflags_q <= 5'b00010;
        end
        EVIM_X_STMIS:
        begin
          target_q <= vbase_q + EVIM_GEN_OFS;
          cause_q <= EVIM_CC_STMIS;
          exl_q <= 1'b1;
        end
        EVIM_X_BUS:
        begin
          target_q <= vbase_q + EVIM_GEN_OFS;
          cause_q <= EVIM_CC_BUS;
          exl_q <= 1'b1;
        end
        default:
        begin
          // imprecise instr, load, store break bits
          target_q <= probe_attached_i ? EVIM_DBG_PROBE : EVIM_DBG_NOPROBE;
          dbg_q <= 1'b1;
          dflags_q <= {complex_break_kind_i, 2'b00};
        end
      endcase
    end
    else if (taking)
    begin
      target_q <= vbase_q + spacing_q * {27'h0, best_n};
      cause_q <= EVIM_CC_INT;
      ipl_q <= best_p[4:2];
      exl_q <= 1'b1;
    end
    else if (reg_wr_i && reg_addr_i == EVIM_OFS_LEVEL)
    begin
      // software return path: restore level and leave exception
      ipl_q <= reg_wdata_i[2:0];
      exl_q <= reg_wdata_i[8];
      dbg_q <= reg_wdata_i[9];
    end
  end

  // flag bits, set wins over write-one-to-clear
  logic [NUM_VEC-1:0] flag_clr;
  assign flag_clr = (reg_wr_i && reg_addr_i == EVIM_OFS_FLAG) ?
                    reg_wdata_i[NUM_VEC-1:0] : '0;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      flag_q <= '0;
    else
      flag_q <= ((flag_q & ~flag_clr) | src_vec) &
                EVIM_VALID_VEC[NUM_VEC-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      enable_q <= '0;
    else if (reg_wr_i && reg_addr_i == EVIM_OFS_ENABLE)
      enable_q <= reg_wdata_i[NUM_VEC-1:0];
  end

  // exception status: sticky, write one to clear, set wins
  logic [EVIM_NUM_EXC-1:0] stat_clr;
  assign stat_clr = (reg_wr_i && reg_addr_i == EVIM_OFS_EXC_STAT) ?
                    reg_wdata_i[EVIM_NUM_EXC-1:0] : '0;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      exc_stat_q <= '0;
    else
      exc_stat_q <= (exc_stat_q & ~stat_clr) | exc_evt;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      exc_mask_q <= '0;
      vbase_q <= EVIM_VBASE_RST;
      spacing_q <= EVIM_SPACING_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == EVIM_OFS_EXC_MASK)
        exc_mask_q <= reg_wdata_i[EVIM_NUM_EXC-1:0];
      if (reg_addr_i == EVIM_OFS_VBASE)
        vbase_q <= {reg_wdata_i[31:12], 12'h000};
      if (reg_addr_i == EVIM_OFS_SPACING)
        spacing_q <= {22'h0, reg_wdata_i[9:3], 3'h0};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      irq_q <= 1'b0;
    else
      irq_q <= |(exc_stat_q & exc_mask_q);
  end

  // stop at the last implemented word so higher offsets do not alias word 0
  assign prio_we = reg_wr_i && reg_addr_i >= EVIM_OFS_PRIO0
                   && reg_addr_i < PRIO_END;

  evim_prio_ram #(
    .WORDS(EVIM_PRIO_WORDS),
    .AW(PAW)
  ) u_prio (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(prio_we),
    .waddr_i(PAW'((reg_addr_i - EVIM_OFS_PRIO0) >> 2)),
    .wdata_i(reg_wdata_i),
    .raddr_i(PAW'((reg_addr_i - EVIM_OFS_PRIO0) >> 2)),
    .rdata_o(prio_rdata),
    .all_o(prio_all)
  );

  // read data one cycle after strobe; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_q <= 32'h0000_0000;
      rd_prio_q <= 1'b0;
    end
    else
    begin
      rd_prio_q <= reg_rd_i && reg_addr_i >= EVIM_OFS_PRIO0
                   && reg_addr_i < PRIO_END;
      rdata_q <= 32'h0000_0000;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          EVIM_OFS_FLAG: rdata_q <= 32'(flag_q);
          EVIM_OFS_ENABLE: rdata_q <= 32'(enable_q);
          EVIM_OFS_EXC_STAT: rdata_q <= 32'(exc_stat_q);
          EVIM_OFS_EXC_MASK: rdata_q <= 32'(exc_mask_q);
          EVIM_OFS_VBASE: rdata_q <= vbase_q;
          EVIM_OFS_SPACING: rdata_q <= spacing_q;
          EVIM_OFS_CAUSE: rdata_q <= {27'h0, cause_q};
          EVIM_OFS_TARGET: rdata_q <= target_q;
          EVIM_OFS_LEVEL: rdata_q <= {22'h0, dbg_q, exl_q, 5'h0, ipl_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata_o = rd_prio_q ? prio_rdata : rdata_q;
  assign exc_req_o = (state_q == EVIM_HOLD);
  assign exc_target_o = target_q;
  assign cause_code_o = cause_q;
  assign exception_level_o = exl_q;
  assign coprocessor_unusable_field_o = cu_q;
  assign debug_mode_o = dbg_q;
  assign debug_flags_o = dflags_q;
  assign current_priority_level_o = ipl_q;
  assign irq_o = irq_q;
endmodule

// ==== design/evim_pkg.sv ====
// evim_pkg: constants for the exception vector and interrupt map block.
// assumes a single clock domain and a plain register port.
package evim_pkg;
  localparam int EVIM_NUM_VEC = 26;
  localparam int EVIM_AW = 8;
  // register offsets (word aligned byte addresses)
  localparam logic [7:0] EVIM_OFS_FLAG = 8'h00;
  localparam logic [7:0] EVIM_OFS_ENABLE = 8'h04;
  localparam logic [7:0] EVIM_OFS_PRIO0 = 8'h10;
  localparam logic [7:0] EVIM_OFS_EXC_STAT = 8'h40;
  localparam logic [7:0] EVIM_OFS_EXC_MASK = 8'h44;
  localparam logic [7:0] EVIM_OFS_CTRL = 8'h48;
  localparam logic [7:0] EVIM_OFS_VBASE = 8'h4C;
  localparam logic [7:0] EVIM_OFS_SPACING = 8'h50;
  localparam logic [7:0] EVIM_OFS_CAUSE = 8'h54;
  localparam logic [7:0] EVIM_OFS_TARGET = 8'h58;
  localparam logic [7:0] EVIM_OFS_LEVEL = 8'h5C;
  localparam int EVIM_PRIO_WORDS = 7;
  // cause codes
  localparam logic [4:0] EVIM_CC_INT = 5'h00;
  localparam logic [4:0] EVIM_CC_STMIS = 5'h05;
  localparam logic [4:0] EVIM_CC_BUS = 5'h07;
  localparam logic [4:0] EVIM_CC_RSV = 5'h0A;
  localparam logic [4:0] EVIM_CC_CPU = 5'h0B;
  localparam logic [4:0] EVIM_CC_OVF = 5'h0C;
  localparam logic [4:0] EVIM_CC_TRAP = 5'h0D;
  // vector targets
  localparam logic [31:0] EVIM_GEN_OFS = 32'h0000_0180;
  localparam logic [31:0] EVIM_DBG_NOPROBE = 32'hBFC0_0480;
  localparam logic [31:0] EVIM_DBG_PROBE = 32'hBFC0_0200;
  // reset values
  localparam logic [31:0] EVIM_VBASE_RST = 32'h9D00_0000;
  localparam logic [31:0] EVIM_SPACING_RST = 32'h0000_0020;
  // exception classes in priority order (index 0 highest)
  localparam int EVIM_NUM_EXC = 9;
  localparam int EVIM_X_CPU = 0;
  localparam int EVIM_X_RSV = 1;
  localparam int EVIM_X_OVF = 2;
  localparam int EVIM_X_TRAP = 3;
  localparam int EVIM_X_DBL = 4;
  localparam int EVIM_X_DBS = 5;
  localparam int EVIM_X_STMIS = 6;
  localparam int EVIM_X_BUS = 7;
  localparam int EVIM_X_COMPLEX_BREAKPOINT = 8;
  // valid source vectors: 0..11, 17..19, 23..25
  localparam logic [25:0] EVIM_VALID_VEC = 26'h38E_0FFF;
  typedef enum logic [1:0] {
    EVIM_IDLE = 2'b00,
    EVIM_TAKE = 2'b01,
    EVIM_HOLD = 2'b10
  } evim_state_type;
endpackage

// ==== design/evim_prio_ram.sv ====
// evim_prio_ram: small register array for the priority words.
// assumes one writer and one reader; read data are registered.
`timescale 1ns/10ps
module evim_prio_ram #(
  parameter int WORDS = 7,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  // read port
  input wire logic [AW-1:0] raddr_i,
  output logic [31:0] rdata_o,
  // flat view for the arbiter
  output logic [WORDS*32-1:0] all_o
);
  logic [31:0] mem_q [WORDS];
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_q[i] <= 32'h0000_0000;
    end
    else if (we_i && (int'(waddr_i) < WORDS))
    begin
      // only priority and subpriority bits are implemented
      mem_q[waddr_i] <= wdata_i & 32'h1F1F_1F1F;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rdata_o <= 32'h0000_0000;
    else if (int'(raddr_i) < WORDS)
      rdata_o <= mem_q[raddr_i];
    else
      rdata_o <= 32'h0000_0000;
  end
  genvar g;
  generate
    for (g = 0; g < WORDS; g++)
    begin : g_flat
      assign all_o[g*32 +: 32] = mem_q[g];
    end
  endgenerate
endmodule

// ==== dv/evim_core_model.sv ====
// evim_core_model: core side that acknowledges each exception request.
// assumes exc_req_i stays high until the edge after the acknowledge.
`timescale 1ns/10ps
module evim_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // request from the block and chosen answer delay
  input wire logic exc_req_i,
  input wire logic [3:0] delay_i,
  // acknowledge back to the block
  output logic exc_ack_o
);
  logic [3:0] wait_q;
  logic done_q;
  // done_q keeps a second pulse off while the request is dropping
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !exc_req_i)
    begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
      exc_ack_o <= 1'b0;
    end
    else if (done_q)
      exc_ack_o <= 1'b0;
    else if (wait_q == delay_i)
    begin
      exc_ack_o <= 1'b1;
      done_q <= 1'b1;
    end
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule

// ==== dv/evim_top_monitor.sv ====
// evim_top_monitor: concurrent checks on the core side of evim_top.
// assumes events are one-cycle pulses on the single clock.
`timescale 1ns/10ps
module evim_monitor
  import evim_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // core events
  input wire logic cop_unusable_i,
  input wire logic reserved_opcode_fault_i,
  input wire logic signed_arith_excess_i,
  input wire logic trap_exec_i,
  input wire logic trap_cond_i,
  input wire logic data_break_load_i,
  input wire logic data_break_store_i,
  input wire logic store_misalign_i,
  input wire logic load_store_bus_fault_i,
  input wire logic complex_breakpoint_i,
  input wire logic probe_attached_i,
  input wire logic exc_ack_i,
  // core side
  input wire logic exc_req_o,
  input wire logic [31:0] exc_target_o,
  input wire logic [4:0] cause_code_o,
  input wire logic exception_level_o,
  input wire logic [4:0] debug_flags_o,
  input wire logic [2:0] current_priority_level_o
);
  logic hi_exc;
  logic any_exc;
  assign hi_exc = cop_unusable_i | reserved_opcode_fault_i |
    signed_arith_excess_i | (trap_exec_i & trap_cond_i);
  assign any_exc = hi_exc | data_break_load_i | data_break_store_i |
    store_misalign_i | load_store_bus_fault_i | complex_breakpoint_i;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_cpu_first: assert property (
    $rose(exc_req_o) && $past(cop_unusable_i) |->
      cause_code_o == EVIM_CC_CPU && exception_level_o &&
      exc_target_o[11:0] == 12'h180)
    else $error("coprocessor take wrong");
  a_ovf_code: assert property (
    $rose(exc_req_o) && $past(signed_arith_excess_i &&
      !cop_unusable_i && !reserved_opcode_fault_i) |->
      cause_code_o == EVIM_CC_OVF && exc_target_o[11:0] == 12'h180)
    else $error("overflow take wrong");
  a_stmis_code: assert property (
    $rose(exc_req_o) && $past(store_misalign_i && !hi_exc &&
      !data_break_load_i && !data_break_store_i) |->
      cause_code_o == EVIM_CC_STMIS && exception_level_o)
    else $error("misaligned store take wrong");
  a_dbg_target: assert property (
    $rose(exc_req_o) &&
      $past((data_break_load_i | data_break_store_i) && !hi_exc) |->
      exc_target_o == ($past(probe_attached_i) ? EVIM_DBG_PROBE :
      EVIM_DBG_NOPROBE) && ($past(data_break_load_i) ?
      debug_flags_o[0] : debug_flags_o[1]))
    else $error("data break take wrong");
  a_req_holds: assert property (
    exc_req_o && !exc_ack_i |=> exc_req_o)
    else $error("request dropped before acknowledge");
  a_req_ends: assert property (
    exc_req_o && exc_ack_i |=> !exc_req_o)
    else $error("request kept after acknowledge");
  a_tgt_stable: assert property (
    exc_req_o && $past(exc_req_o) |-> $stable(exc_target_o) &&
      $stable(cause_code_o))
    else $error("target changed while requesting");
  a_int_taken: assert property (
    $rose(exc_req_o) && !$past(any_exc) |->
      cause_code_o == EVIM_CC_INT && exception_level_o &&
      !$past(exception_level_o) &&
      current_priority_level_o > $past(current_priority_level_o))
    else $error("interrupt take wrong");
endmodule
bind evim_top evim_monitor mon_u (.clk_i, .sys_rst_i, .cop_unusable_i,
  .reserved_opcode_fault_i, .signed_arith_excess_i, .trap_exec_i,
  .trap_cond_i, .data_break_load_i, .data_break_store_i,
  .store_misalign_i, .load_store_bus_fault_i, .complex_breakpoint_i,
  .probe_attached_i, .exc_ack_i, .exc_req_o, .exc_target_o,
  .cause_code_o, .exception_level_o, .debug_flags_o,
  .current_priority_level_o);

// ==== dv/evim_top_test.sv ====
// evim_top_test: exception rows, status and irq, interrupt map, reset.
// assumes evim_core_model answers every request.
`timescale 1ns/10ps
module evim_top_test;
  import evim_pkg::*;
  typedef struct packed {
    logic [8:0] ev;
    logic pr;
    logic [4:0] cc;
    logic [31:0] tg;
    logic xl;
    logic [4:0] fm;
  } evim_row_type;
  localparam logic [31:0] GV = EVIM_VBASE_RST + EVIM_GEN_OFS;
  localparam logic [31:0] NP = EVIM_DBG_NOPROBE;
  localparam logic [31:0] PB = EVIM_DBG_PROBE;
  // debug rows keep the cause of the row before them
  localparam evim_row_type ROWS [12] = '{
    '{9'h001, 1'b0, EVIM_CC_CPU, GV, 1'b1, 5'h00},
    '{9'h002, 1'b0, EVIM_CC_RSV, GV, 1'b1, 5'h00},
    '{9'h004, 1'b0, EVIM_CC_OVF, GV, 1'b1, 5'h00},
    '{9'h008, 1'b0, EVIM_CC_TRAP, GV, 1'b1, 5'h00},
    '{9'h040, 1'b0, EVIM_CC_STMIS, GV, 1'b1, 5'h00},
    '{9'h080, 1'b0, EVIM_CC_BUS, GV, 1'b1, 5'h00},
    '{9'h010, 1'b0, EVIM_CC_BUS, NP, 1'b0, 5'h01},
    '{9'h020, 1'b1, EVIM_CC_BUS, PB, 1'b0, 5'h02},
    '{9'h100, 1'b0, EVIM_CC_BUS, NP, 1'b0, 5'h14},
    '{9'h1FE, 1'b1, EVIM_CC_RSV, GV, 1'b1, 5'h00},
    '{9'h1C0, 1'b0, EVIM_CC_STMIS, GV, 1'b1, 5'h00},
    '{9'h030, 1'b1, EVIM_CC_STMIS, PB, 1'b0, 5'h01}};
  localparam logic [4:0] IV [3] = '{5'h12, 5'h11, 5'h03};
  localparam logic [2:0] IL [3] = '{3'h5, 3'h5, 3'h3};
  logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, exc_ack_i, core_timer_i;
  logic [EVIM_AW-1:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, exc_target_o, d;
  logic cop_unusable_i, reserved_opcode_fault_i, signed_arith_excess_i;
  logic trap_exec_i, trap_cond_i, data_break_load_i, data_break_store_i;
  logic store_misalign_i, load_store_bus_fault_i, complex_breakpoint_i;
  logic probe_attached_i, exc_req_o, exception_level_o, debug_mode_o;
  logic irq_o;
  logic [3:0] cop_num_i, change_notice_i, coprocessor_unusable_field_o;
  logic [3:0] dly;
  logic [2:0] complex_break_kind_i, timer_irq_i, comparator_irq_i;
  logic [2:0] current_priority_level_o;
  logic [1:0] core_soft_i;
  logic [4:0] ext_irq_i, cause_code_o, debug_flags_o;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  evim_top dut_u (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cop_unusable_i, .cop_num_i,
    .reserved_opcode_fault_i, .signed_arith_excess_i, .trap_exec_i,
    .trap_cond_i, .data_break_load_i, .data_break_store_i,
    .store_misalign_i, .load_store_bus_fault_i, .complex_breakpoint_i,
    .complex_break_kind_i, .probe_attached_i, .exc_ack_i, .core_timer_i,
    .core_soft_i, .ext_irq_i, .change_notice_i, .timer_irq_i,
    .comparator_irq_i, .exc_req_o, .exc_target_o, .cause_code_o,
    .exception_level_o, .coprocessor_unusable_field_o, .debug_mode_o,
    .debug_flags_o, .current_priority_level_o, .irq_o);
  evim_core_model model_u (.clk_i, .sys_rst_i, .exc_req_i(exc_req_o),
    .delay_i(dly), .exc_ack_o(exc_ack_i));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // a hung handshake ends here instead of running forever
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
  endtask
  // ev[9] is the trap condition, sampled beside the trap pulse
  task automatic fire(input logic [9:0] ev, input logic pr);
    @(posedge clk_i);
    {trap_cond_i, complex_breakpoint_i, load_store_bus_fault_i,
      store_misalign_i, data_break_store_i, data_break_load_i,
      trap_exec_i, signed_arith_excess_i, reserved_opcode_fault_i,
      cop_unusable_i} <= ev;
    probe_attached_i <= pr;
    @(posedge clk_i);
    {trap_cond_i, complex_breakpoint_i, load_store_bus_fault_i,
      store_misalign_i, data_break_store_i, data_break_load_i,
      trap_exec_i, signed_arith_excess_i, reserved_opcode_fault_i,
      cop_unusable_i} <= 10'h000;
    #1;
  endtask
  task automatic wait_req(input logic v);
    int i;
    i = 0;
    while (exc_req_o !== v && i < 40)
    begin
      @(posedge clk_i);
      #1;
      i++;
    end
    chk(exc_req_o, v);
  endtask
  initial
  begin
    sys_rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, core_timer_i} = '0;
    {trap_cond_i, complex_breakpoint_i, load_store_bus_fault_i,
      store_misalign_i, data_break_store_i, data_break_load_i,
      trap_exec_i, signed_arith_excess_i, reserved_opcode_fault_i,
      cop_unusable_i, probe_attached_i} = '0;
    {core_soft_i, ext_irq_i, change_notice_i, timer_irq_i} = '0;
    comparator_irq_i = 3'h0;
    cop_num_i = 4'h2;
    complex_break_kind_i = 3'h5;
    dly = 4'h0;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (ROWS[i])
    begin
      wr(EVIM_OFS_LEVEL, 32'h0);
      dly <= 4'((i % 3) * 2);
      fire({ROWS[i].ev[3], ROWS[i].ev}, ROWS[i].pr);
      wait_req(1'b1);
      chk(cause_code_o, ROWS[i].cc);
      chk(exc_target_o, ROWS[i].tg);
      chk(exception_level_o, ROWS[i].xl);
      chk(debug_flags_o & ROWS[i].fm, ROWS[i].fm);
      chk(debug_mode_o, ROWS[i].tg != GV);
      if (i == 0)
        chk(coprocessor_unusable_field_o, 4'h2);
      wait_req(1'b0);
    end
    $display("exception rows done");
    rd(EVIM_OFS_EXC_STAT, d);
    chk(d, 32'h0000_01FF);
    chk(irq_o, 1'b0);
    wr(EVIM_OFS_EXC_MASK, 32'h0000_0040);
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq_o, 1'b1);
    wr(EVIM_OFS_EXC_STAT, 32'h0000_01FF);
    repeat (2) @(posedge clk_i);
    #1;
    chk(irq_o, 1'b0);
    fire(10'h008, 1'b0);
    repeat (5) @(posedge clk_i);
    #1;
    chk(exc_req_o, 1'b0);
    rd(EVIM_OFS_EXC_STAT, d);
    chk(d, 32'h0);
    rd(8'h4C, d);
    chk(d, 32'h9D00_0000);
    rd(EVIM_OFS_CTRL, d);
    chk(d, 32'h0);
    rd(8'h60, d);
    chk(d, 32'h0);
    $display("status and irq done");
    wr(EVIM_OFS_PRIO0, 32'hFFFF_FFFF);
    rd(EVIM_OFS_PRIO0, d);
    chk(d, 32'h1F1F_1F1F);
    @(posedge clk_i);
    {core_timer_i, core_soft_i, ext_irq_i, change_notice_i, timer_irq_i,
      comparator_irq_i} <= 18'h3FFFF;
    @(posedge clk_i);
    {core_timer_i, core_soft_i, ext_irq_i, change_notice_i, timer_irq_i,
      comparator_irq_i} <= 18'h00000;
    rd(EVIM_OFS_FLAG, d);
    chk(d, 32'h038E_0FFF);
    wr(EVIM_OFS_FLAG, 32'h03FF_FFFF);
    wr(EVIM_OFS_PRIO0, 32'h0D00_0000);
    wr(EVIM_OFS_PRIO0 + 8'h10, 32'h0016_1400);
    wr(EVIM_OFS_LEVEL, 32'h0);
    wr(EVIM_OFS_ENABLE, 32'h0006_0008);
    @(posedge clk_i);
    ext_irq_i <= 5'h01;
    timer_irq_i <= 3'h3;
    @(posedge clk_i);
    ext_irq_i <= 5'h00;
    timer_irq_i <= 3'h0;
    foreach (IV[j])
    begin
      wait_req(1'b1);
      chk(exc_target_o, EVIM_VBASE_RST + EVIM_SPACING_RST * IV[j]);
      chk(cause_code_o, EVIM_CC_INT);
      chk(current_priority_level_o, IL[j]);
      wait_req(1'b0);
      wr(EVIM_OFS_FLAG, 32'h1 << IV[j]);
      wr(EVIM_OFS_LEVEL, 32'h0);
    end
    wr(8'h30, 32'h0000_001F);
    wr(EVIM_OFS_ENABLE, 32'h0000_0001);
    @(posedge clk_i);
    core_timer_i <= 1'b1;
    @(posedge clk_i);
    core_timer_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk(exc_req_o, 1'b0);
    rd(8'h30, d);
    chk(d, 32'h0);
    $display("interrupt map done");
    wr(EVIM_OFS_LEVEL, 32'h0000_0105);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(exception_level_o, 1'b0);
    chk(current_priority_level_o, 3'h0);
    rd(EVIM_OFS_ENABLE, d);
    chk(d, 32'h0);
    $display("reset done");
    complete_run();
  end
endmodule
